// *** hdl/ssp_port.sv ***
// Synchronous serial peripheral port: master or slave byte exchange.
// Assumes pins are synchronous to core_clk; pin output enables active low.
//
// Contract
// - Outputs drive only with direction bit set
// - Inputs used regardless of direction bit
// - Data-in input as master, output as slave
// - Shift most significant bit first
// - Unselected slave releases its data output
// - Data-out output as master, input slave
// - Eight clock cycles exchange one byte
// - Master makes clock; slave takes it in
// - Polarity and phase give four timings
// - Master data leads sampling edge half-cycle
// - Rate bits affect master mode only
// - Four master rates, programmable polarity, phase
// - Master bit rate capped; slave faster; slave clock here is edge-detected on core_clk, so at most divide by 2
// - Done flag, write collision, mode fault
// - Rate codes divide clock 2,4,16,32
// - Idle clock level follows polarity bit
// - Phase zero: select low starts shifting
`timescale 1ns/1ps
module ssp_port
  import ssp_pkg::*;
#(
  parameter int DATA_W = BITS_PER_BYTE
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire ssp_ctrl_s         ctrl,
  input  wire ssp_dir_s          pinDir,
  input  wire logic              wireOrMode,
  // Transmit write port
  input  wire logic [DATA_W-1:0] txData,
  input  wire logic              txValid,
  output logic                   txReady,
  // Received byte stream through the two-entry buffer
  output logic [DATA_W-1:0]      rxData,
  output logic                   rxValid,
  input  wire logic              rxReady,
  // Status flags, cleared by a one-cycle pulse
  input  wire logic              flagClear,
  output logic                   transferDoneFlag,
  output logic                   writeCollisionFlag,
  output logic                   modeFaultFlag,
  output logic                   modeFaultEvent,
  output logic                   busy,
  // Pins, three signals each except selectN; enables low while driving
  input  wire logic              sclkIn,
  output logic                   sclkOut,
  output logic                   sclkOeN,
  input  wire logic              mosiIn,
  output logic                   mosiOut,
  output logic                   mosiOeN,
  input  wire logic              misoIn,
  output logic                   misoOut,
  output logic                   misoOeN,
  input  wire logic              selectN
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Half-period in core cycles for a rate code
  function automatic logic [4:0] half_div(input logic [1:0] code);
    unique case (code)
      2'h0: half_div = 5'(RATE_DIV_0 / 2);
      2'h1: half_div = 5'(RATE_DIV_1 / 2);
      2'h2: half_div = 5'(RATE_DIV_2 / 2);
      2'h3: half_div = 5'(RATE_DIV_3 / 2);
    endcase
  endfunction : half_div

  // ----------------------------------------------------------------
  // Input edge detection
  // ----------------------------------------------------------------
  logic sclkPrev;
  logic selPrevN;
  logic next_sclkPrev;
  logic next_selPrevN;
  logic slaveClk;
  logic sampleEdge;
  logic shiftEdge;
  logic slaveSel;

  // Polarity acts like an inverter in series with the clock
  always_comb begin
    next_sclkPrev = sclkIn;
    next_selPrevN = selectN;
    slaveClk      = sclkIn ^ ctrl.clockPolarity;
    slaveSel      = ~selectN;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      // Clock history starts from the pin level, so no false clock edge follows reset; select history starts high
      sclkPrev <= next_sclkPrev;
      selPrevN <= 1'h1;
    end else begin
      sclkPrev <= next_sclkPrev;
      selPrevN <= next_selPrevN;
    end
  end

  logic prevSlaveClk;
  assign prevSlaveClk = sclkPrev ^ ctrl.clockPolarity;
  // Leading edge samples for phase 0, trailing edge for phase 1
  assign sampleEdge = ctrl.clockPhase ? (prevSlaveClk & ~slaveClk)
                                      : (~prevSlaveClk & slaveClk);
  assign shiftEdge  = ctrl.clockPhase ? (~prevSlaveClk & slaveClk)
                                      : (prevSlaveClk & ~slaveClk);

  // ----------------------------------------------------------------
  // Receive buffer (two entries)
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] bufMem [2];
  logic [DATA_W-1:0] next_bufMem [2];
  logic              bufWr;
  logic              bufRd;
  logic [1:0]        bufCount;
  logic [1:0]        next_bufCount;
  logic              bufHead;
  logic              next_bufHead;
  logic [DATA_W-1:0] bufIn;
  logic              bufInReady;

  assign bufInReady = (bufCount != 2'h2);
  assign rxValid    = (bufCount != 2'h0);
  assign rxData     = bufMem[bufHead];
  assign bufRd      = rxValid & rxReady;

  always_comb begin
    logic wrIdx;
    wrIdx         = bufHead ^ (bufCount != 2'h0);
    next_bufMem   = bufMem;
    next_bufHead  = bufHead;
    next_bufCount = bufCount;
    if (bufWr && bufInReady) begin
      next_bufMem[wrIdx] = bufIn;
    end
    if (bufRd) begin
      next_bufHead = ~bufHead;
    end
    next_bufCount = 2'(bufCount + 2'(bufWr & bufInReady) - 2'(bufRd));
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      bufMem   <= '{default: '0};
      bufHead  <= 1'h0;
      bufCount <= 2'h0;
    end else begin
      bufMem   <= next_bufMem;
      bufHead  <= next_bufHead;
      bufCount <= next_bufCount;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  ssp_state_e        state;
  ssp_state_e        next_state;
  logic [DATA_W-1:0] shiftReg;
  logic [DATA_W-1:0] next_shiftReg;
  logic [3:0]        bitCount;
  logic [3:0]        next_bitCount;
  logic [4:0]        divCount;
  logic [4:0]        next_divCount;
  logic              mClk;
  logic              next_mClk;
  logic              outBit;
  logic              next_outBit;
  logic              inBit;
  logic              next_inBit;
  logic              doneF;
  logic              next_doneF;
  logic              wcolF;
  logic              next_wcolF;
  logic              modfF;
  logic              next_modfF;
  logic              faultPulse;
  logic              inTransfer;

  // Mode fault when a master sees its select pulled low
  assign faultPulse = ctrl.enable & ctrl.master & slaveSel;
  // Refuse writes while the receive buffer is full; a slave transfer still runs and its byte is lost
  assign txReady    = ctrl.enable & (state == SSP_IDLE) & bufInReady;
  assign inTransfer = (state != SSP_IDLE) | (~ctrl.master & slaveSel & ~ctrl.clockPhase);

  always_comb begin
    next_state    = state;
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    next_divCount = divCount;
    next_mClk     = mClk;
    next_outBit   = outBit;
    next_inBit    = inBit;
    next_doneF    = doneF;
    next_wcolF    = wcolF;
    next_modfF    = modfF;
    bufWr         = 1'h0;
    bufIn         = shiftReg;
    // Clear first so that a same-cycle event wins
    if (flagClear) begin
      next_doneF = 1'h0;
      next_wcolF = 1'h0;
      next_modfF = 1'h0;
    end
    if (txValid && !txReady && ctrl.enable && inTransfer) begin
      next_wcolF = 1'h1;
    end
    unique case (state)
      SSP_IDLE: begin
        next_mClk     = 1'h0;
        next_bitCount = 4'h0;
        next_divCount = 5'h0;
        if (txValid && txReady) begin
          next_shiftReg = txData;
          next_outBit   = txData[DATA_W-1];
          next_state    = SSP_RUN;
        end else if (!ctrl.master && slaveSel && (selPrevN || ctrl.clockPhase)) begin
          // Slave without a fresh byte still shifts what it holds
          next_outBit = shiftReg[DATA_W-1];
          if (selPrevN || shiftEdge || sampleEdge) begin
            next_state = SSP_RUN;
          end
        end
      end
      SSP_RUN: begin
        if (ctrl.master) begin
          // Rate bits only steer the master divider
          // Bit rate cap needs a slow core clock; divide by 2 is the fastest
          if (divCount == 5'(half_div(ctrl.rateSelect) - 5'h1)) begin
            next_divCount = 5'h0;
            next_mClk     = ~mClk;
            if (!mClk ^ ctrl.clockPhase) begin
              // Sampling edge; data was set half a cycle earlier
              next_inBit = misoIn;
            end else if (!ctrl.clockPhase || bitCount != 4'h0) begin
              // Phase one keeps the first bit over the first leading edge
              next_shiftReg = {shiftReg[DATA_W-2:0], inBit};
              next_outBit   = shiftReg[DATA_W-2];
            end
            if (mClk) begin
              next_bitCount = 4'(bitCount + 4'h1);
            end
            if (mClk && bitCount == 4'(DATA_W - 1)) begin
              // Phase one samples the last bit on this very edge
              next_shiftReg = ctrl.clockPhase ? {shiftReg[DATA_W-2:0], misoIn}
                                              : {shiftReg[DATA_W-2:0], inBit};
              next_state    = SSP_DONE;
            end
          end else begin
            next_divCount = 5'(divCount + 5'h1);
          end
        end else begin
          // Slave follows the partner clock; select must stay low
          if (!slaveSel) begin
            next_state = SSP_IDLE;
          end else if (sampleEdge) begin
            next_inBit    = mosiIn;
            next_bitCount = 4'(bitCount + 4'h1);
            if (bitCount == 4'(DATA_W - 1)) begin
              next_shiftReg = {shiftReg[DATA_W-2:0], mosiIn};
              next_state    = SSP_DONE;
            end
          end else if (shiftEdge && bitCount != 4'h0) begin
            next_shiftReg = {shiftReg[DATA_W-2:0], inBit};
            next_outBit   = shiftReg[DATA_W-2];
          end
        end
      end
      SSP_DONE: begin
        bufWr       = 1'h1;
        next_doneF  = 1'h1;
        next_mClk   = 1'h0;
        next_outBit = shiftReg[DATA_W-1];
        next_state  = SSP_IDLE;
      end
    endcase
    // Mode fault forces the engine back to idle
    if (faultPulse || !ctrl.enable) begin
      next_state = SSP_IDLE;
      next_mClk  = 1'h0;
    end
    if (faultPulse) begin
      next_modfF = 1'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state    <= SSP_IDLE;
      shiftReg <= '0;
      bitCount <= 4'h0;
      divCount <= 5'h0;
      mClk     <= 1'h0;
      outBit   <= 1'h0;
      inBit    <= 1'h0;
      doneF    <= 1'h0;
      wcolF    <= 1'h0;
      modfF    <= 1'h0;
    end else begin
      state    <= next_state;
      shiftReg <= next_shiftReg;
      bitCount <= next_bitCount;
      divCount <= next_divCount;
      mClk     <= next_mClk;
      outBit   <= next_outBit;
      inBit    <= next_inBit;
      doneF    <= next_doneF;
      wcolF    <= next_wcolF;
      modfF    <= next_modfF;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Each output needs its direction bit; inputs ignore it
  logic drvSclk;
  logic drvMosi;
  logic drvMiso;
  assign drvSclk = ctrl.enable & ctrl.master & pinDir.sclk;
  assign drvMosi = ctrl.enable & ctrl.master & pinDir.mosi;
  assign drvMiso = ctrl.enable & ~ctrl.master & slaveSel & pinDir.miso;

  assign sclkOut = mClk ^ ctrl.clockPolarity;
  assign mosiOut = outBit;
  assign misoOut = outBit;
  // Open-drain mode releases the pin whenever it would drive high
  assign sclkOeN = ~(drvSclk & ~(wireOrMode & sclkOut));
  assign mosiOeN = ~(drvMosi & ~(wireOrMode & mosiOut));
  assign misoOeN = ~(drvMiso & ~(wireOrMode & misoOut));

  assign transferDoneFlag   = doneF;
  assign writeCollisionFlag = wcolF;
  assign modeFaultFlag      = modfF;
  assign modeFaultEvent     = faultPulse;
  assign busy               = (state != SSP_IDLE);

endmodule : ssp_port

// *** pkg/ssp_pkg.sv ***
// Package for the synchronous serial peripheral port.
// Assumes a single core clock; all pins sampled synchronously.
package ssp_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_CLK_MHZ      = 40;
  localparam int BITS_PER_BYTE     = 8;
  // Divider ratios for rate codes 00, 01, 10, 11
  localparam int RATE_DIV_0        = 2;
  localparam int RATE_DIV_1        = 4;
  localparam int RATE_DIV_2        = 16;
  localparam int RATE_DIV_3        = 32;
  localparam logic [1:0] RESET_RATE = 2'h0;
  localparam logic       RESET_PHASE = 1'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_IDLE,
    SSP_RUN,
    SSP_DONE
  } ssp_state_e;

  // Control bits from the serial port control word
  typedef struct packed {
    logic       enable;
    logic       master;
    logic       clockPolarity;
    logic       clockPhase;
    logic [1:0] rateSelect;   // {rate_select_high, rate_select_low}
  } ssp_ctrl_s;

  // Per-pin direction bits (set = port may drive)
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic miso;
  } ssp_dir_s;

endpackage : ssp_pkg

// *** testbench/ssp_port_sva.sv ***
// Checker for the serial port, bound into every ssp_port.
// Assumes one core clock and srst synchronous, active high.
`timescale 1ns/1ps
module ssp_port_sva
  import ssp_pkg::*;
(
  input wire logic      core_clk,
  input wire logic      srst,
  input wire ssp_ctrl_s ctrl,
  input wire ssp_dir_s  pinDir,
  input wire logic      txValid,
  input wire logic      txReady,
  input wire logic      rxValid,
  input wire logic      transferDoneFlag,
  input wire logic      writeCollisionFlag,
  input wire logic      modeFaultFlag,
  input wire logic      busy,
  input wire logic      selectN,
  input wire logic      sclkOut,
  input wire logic      sclkOeN,
  input wire logic      mosiOeN,
  input wire logic      misoOeN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ----
  // Cycles since a master byte was taken
  // ----
  int   cnt, expDly, next_cnt, next_expDly;
  logic run, take;
  assign run  = ctrl.enable & ctrl.master;
  assign take = txValid & txReady & run;
  // Expected latency latched at the take, so later rate changes cannot skew it
  always_comb begin
    next_cnt    = (cnt == 0) ? 0 : cnt + 1;
    next_expDly = expDly;
    if (take) begin
      next_cnt = 1;
      case (ctrl.rateSelect)
        2'h0: next_expDly = BITS_PER_BYTE * RATE_DIV_0 + 2;
        2'h1: next_expDly = BITS_PER_BYTE * RATE_DIV_1 + 2;
        2'h2: next_expDly = BITS_PER_BYTE * RATE_DIV_2 + 2;
        default: next_expDly = BITS_PER_BYTE * RATE_DIV_3 + 2;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    cnt    <= srst ? 0 : next_cnt;
    expDly <= srst ? 0 : next_expDly;
  end
  // ----
  // Properties
  // ----
  chk_idle_level: assert property (run && !busy |-> sclkOut == ctrl.clockPolarity)
    else $error("serial clock away from idle level");
  chk_done_time: assert property ($rose(transferDoneFlag) && run |-> cnt == expDly)
    else $error("done flag at wrong cycle");
  chk_rx_done: assert property ($rose(transferDoneFlag) |-> rxValid)
    else $error("no received word with done flag");
  chk_collide_flag: assert property (txValid && busy |=> writeCollisionFlag)
    else $error("write during transfer not flagged");
  chk_fault_flag: assert property (run && !selectN |=> modeFaultFlag)
    else $error("mode fault not flagged");
  chk_busy_refuse: assert property (busy |-> !txReady)
    else $error("write accepted while busy");
  chk_sclk_dir: assert property (!run || !pinDir.sclk |-> sclkOeN)
    else $error("clock pin driven when not allowed");
  chk_mosi_dir: assert property (!run || !pinDir.mosi |-> mosiOeN)
    else $error("data-out pin driven when not allowed");
  chk_miso_dir: assert property (!ctrl.enable || ctrl.master || !pinDir.miso || selectN |-> misoOeN)
    else $error("data-in pin driven when not allowed");
endmodule : ssp_port_sva

bind ssp_port ssp_port_sva u_chk (.core_clk(core_clk), .srst(srst), .ctrl(ctrl), .pinDir(pinDir),
  .txValid(txValid), .txReady(txReady), .rxValid(rxValid), .transferDoneFlag(transferDoneFlag),
  .writeCollisionFlag(writeCollisionFlag), .modeFaultFlag(modeFaultFlag), .busy(busy),
  .selectN(selectN), .sclkOut(sclkOut), .sclkOeN(sclkOeN), .mosiOeN(mosiOeN), .misoOeN(misoOeN));

// *** testbench/ssp_slave_model.sv ***
// Far-side slave seen by the port in master mode.
// Assumes clock and data change only on core_clk edges.
`timescale 1ns/1ps
module ssp_slave_model (
  input wire logic       core_clk,
  input wire logic       sclk,
  input wire logic       mosi,
  input wire logic       selN,
  input wire logic       clock_polarity,
  input wire logic       clock_phase,
  input wire logic [7:0] txByte,
  output logic           miso,
  output logic [7:0]     rxByte
);
  logic       prevClk;
  logic       lastBit = 1'b0;
  logic [7:0] sh;
  // Released line shows the inverse of the last bit, never a held value
  assign miso = selN ? ~lastBit : sh[7];
  // Sample on leading edge for phase zero, trailing for phase one
  always_ff @(posedge core_clk) begin
    prevClk <= sclk;
    if (selN) begin
      sh <= txByte;
    end else if (sclk != prevClk && ((sclk ^ clock_polarity) != clock_phase)) begin
      rxByte  <= {rxByte[6:0], mosi};
      sh      <= {sh[6:0], 1'b0};
      lastBit <= sh[7];
    end
  end
endmodule : ssp_slave_model

// *** testbench/testbench.sv ***
// Self-checking bench: port as master against the model, then as slave.
// Assumes ssp_pkg, the model and the checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import ssp_pkg::*;
  ssp_ctrl_s  ctrl;
  ssp_dir_s   pinDir;
  logic       core_clk, srst, txValid, rxReady, flagClear, sclkIn, mosiIn, selectN, modelSelN;
  logic       txReady, rxValid, transferDoneFlag, writeCollisionFlag, modeFaultFlag, busy, modeFaultEvent;
  logic       sclkOut, sclkOeN, mosiOut, mosiOeN, misoIn, misoOut, misoOeN;
  logic [7:0] txData, rxData, modelTx, modelRx, got;
  logic [7:0] q[$];
  int         failures, compares;

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ssp_port DUT (.core_clk(core_clk), .srst(srst), .ctrl(ctrl), .pinDir(pinDir), .wireOrMode(1'b0),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .flagClear(flagClear), .transferDoneFlag(transferDoneFlag),
    .writeCollisionFlag(writeCollisionFlag), .modeFaultFlag(modeFaultFlag), .modeFaultEvent(modeFaultEvent),
    .busy(busy), .sclkIn(sclkIn), .sclkOut(sclkOut), .sclkOeN(sclkOeN), .mosiIn(mosiIn),
    .mosiOut(mosiOut), .mosiOeN(mosiOeN), .misoIn(misoIn), .misoOut(misoOut), .misoOeN(misoOeN),
    .selectN(selectN));
  ssp_slave_model u_model (.core_clk(core_clk), .sclk(sclkOut), .mosi(mosiOut), .selN(modelSelN),
    .clock_polarity(ctrl.clockPolarity), .clock_phase(ctrl.clockPhase), .txByte(modelTx), .miso(misoIn), .rxByte(modelRx));

  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Bounded wait; a hang counts as a failure and ends the run
  task automatic wait_done();
    int n;
    n = 0;
    while (transferDoneFlag !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) begin
      failures++;
      results();
    end
  endtask : wait_done

  task automatic clear();
    flagClear <= 1'b1;
    tick(1);
    flagClear <= 1'b0;
  endtask : clear

  // Master byte; col writes again while busy, and that byte must be dropped
  task automatic mxfer(input logic [7:0] t, input logic [7:0] m, input logic col);
    modelTx <= m;
    tick(1);
    modelSelN <= 1'b0;
    txData <= t;
    txValid <= 1'b1;
    tick(1);
    check(txReady, 1'b1);
    txValid <= col;
    txData <= ~t;
    tick(1);
    txValid <= 1'b0;
    q.push_back(m);
    wait_done();
    check(writeCollisionFlag, col);
    clear();
    modelSelN <= 1'b1;
    check(modelRx, t);
  endtask : mxfer

  // Bench as master; 14 cycles a bit keeps the clock under the slave limit
  task automatic sxfer(input logic [7:0] b, input logic [7:0] t);
    sclkIn <= ctrl.clockPolarity;
    txData <= t;
    txValid <= 1'b1;
    tick(1);
    txValid <= 1'b0;
    selectN <= 1'b0;
    q.push_back(b);
    for (int i = 7; i >= 0; i--) begin
      mosiIn <= b[i];
      tick(5);
      if (!ctrl.clockPhase) got[i] = misoOut;
      sclkIn <= ~sclkIn;
      tick(7);
      if (ctrl.clockPhase) got[i] = misoOut;
      sclkIn <= ~sclkIn;
      tick(2);
    end
    check(misoOeN, 1'b0);
    wait_done();
    check(got, t);
    selectN <= 1'b1;
    clear();
  endtask : sxfer

  // Received words leave in the order they were noted
  always @(posedge core_clk) begin
    if (rxValid === 1'b1 && rxReady === 1'b1) begin
      check(rxData, (q.size() > 0) ? q.pop_front() : ~rxData);
    end
  end

  // ----
  // Main sequence
  // ----
  initial begin
    srst = 1'b1;
    ctrl = '0;
    pinDir = 3'h7;
    {txValid, flagClear, sclkIn, mosiIn} = 4'h0;
    {rxReady, selectN, modelSelN} = 3'h7;
    txData = 8'h00;
    modelTx = 8'h00;
    failures = 0;
    compares = 0;
    void'($urandom(81));
    tick(4);
    srst <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      ctrl <= ssp_ctrl_s'({2'h3, k[1:0], k[3:2]});
      mxfer(8'($urandom), 8'($urandom), k == 5);
    end
    $display("test master modes done");
    rxReady <= 1'b0;
    mxfer(8'($urandom), 8'($urandom), 1'b0);
    mxfer(8'($urandom), 8'($urandom), 1'b0);
    check(txReady, 1'b0);
    rxReady <= 1'b1;
    tick(3);
    check(rxValid, 1'b0);
    $display("test stalled receiver done");
    pinDir <= 3'h0;
    selectN <= 1'b0;
    tick(1);
    check(modeFaultEvent, 1'b1);
    selectN <= 1'b1;
    tick(1);
    check(modeFaultFlag, 1'b1);
    clear();
    pinDir <= 3'h1;
    $display("test mode fault done");
    for (int k = 0; k < 4; k++) begin
      ctrl <= ssp_ctrl_s'({2'h2, k[1:0], 2'($urandom)});
      tick(1);
      sxfer(8'($urandom), 8'($urandom));
    end
    tick(4);
    check(8'(q.size()), 8'h00);
    $display("test slave modes done");
    results();
  end
endmodule : testbench
